// *** rtl/cwnw_regs.svh ***
// register offsets, field positions, reset values and timing for the config word writer
// assumes an apb slave with 32-bit data, one register per aligned word
`ifndef CWNW_REGS_SVH
`define CWNW_REGS_SVH
`define CWNW_OFF_CTRL 12'h000
`define CWNW_OFF_KEY 12'h004
`define CWNW_OFF_ADRL 12'h008
`define CWNW_OFF_DAT 12'h00C
`define CWNW_OFF_TBLU 12'h010
`define CWNW_OFF_TBLH 12'h014
`define CWNW_OFF_TBLL 12'h018
`define CWNW_OFF_TLAT 12'h01C
`define CWNW_OFF_FLAG 12'h020
`define CWNW_OFF_IEN 12'h024
`define CWNW_OFF_IPRI 12'h028
`define CWNW_OFF_PROT 12'h02C
`define CWNW_BIT_RD 0
`define CWNW_BIT_WR 1
`define CWNW_BIT_WRITE_ENABLE_BIT 2
`define CWNW_BIT_WRITE_ERROR_FLAG 3
`define CWNW_BIT_FREE 4
`define CWNW_BIT_REG0 6
`define CWNW_BIT_DONE 5
`define CWNW_CTRL_MASK 8'hDF
`define CWNW_KEY_FIRST 8'h55
`define CWNW_KEY_SECOND 8'hAA
`define CWNW_RST_IPRI 8'h20
`define CWNW_UID_LO 22'h20_0000
`define CWNW_UID_HI 22'h20_000F
`define CWNW_CFG_LO 22'h30_0000
`define CWNW_CFG_HI 22'h30_000B
`define CWNW_DID_LO 22'h3F_FFFC
`define CWNW_DID_HI 22'h3F_FFFF
`define CWNW_WRITE_NS 2000
`define CWNW_WRITE_CYC ((`CWNW_WRITE_NS + 39) / 40)
`endif

// *** rtl/cwnw_pkg.sv ***
// types shared by the config word writer
// assumes the register header is included by the design file
package cwnw_pkg;
  typedef enum logic [1:0] {CWNW_IDLE, CWNW_ERASE, CWNW_PROG, CWNW_DONE} cwnw_state_e;
  typedef enum logic [1:0] {CWNW_K0, CWNW_K1, CWNW_KOK} cwnw_key_e;
endpackage : cwnw_pkg

// *** rtl/cwnw_top.sv ***
// config word writer: table pointer/latch driven byte writes into user id and config space
// assumes an apb master on ref_clk and a cpu that honours cpu_stall
`timescale 1ns/100ps
`default_nettype none
`include "cwnw_regs.svh"
module cwnw_top
  import cwnw_pkg::*;
#(
  parameter int WRITE_CYC = `CWNW_WRITE_CYC,
  parameter logic [7:0] DEV_ID_VALUE = 8'h5A  // arbitrary identity value
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpu_stall,
  output logic [7:0] cfg_word_out,
  output logic irq_out,
  output logic irq_high_pri
);
  // 16 user id bytes, 12 config bytes
  logic [7:0] uid_mem [16];
  logic [7:0] cfg_mem [12];
  logic [7:0] ctrl_reg, ctrl_next, dat_reg, adrl_reg, tlat_reg, ien_reg, ipri_reg;
  logic [7:0] flag_reg, prot_reg, cfg_out_reg, rdata_reg;
  logic [21:0] tblp_reg;
  logic [15:0] cnt_reg;
  cwnw_state_e st_reg;
  cwnw_key_e key_reg;

  wire wr_acc = psel && penable && pwrite && clk_en;
  wire rd_acc = psel && penable && !pwrite && clk_en;
  wire [11:0] a = paddr;
  wire [7:0] wd = pwdata[7:0];

  function automatic logic in_rng(input logic [21:0] p, input logic [21:0] lo,
                                  input logic [21:0] hi);
    in_rng = (p >= lo) && (p <= hi);
  endfunction : in_rng

  wire is_uid = in_rng(tblp_reg, `CWNW_UID_LO, `CWNW_UID_HI);
  wire is_cfg = in_rng(tblp_reg, `CWNW_CFG_LO, `CWNW_CFG_HI);
  wire is_did = in_rng(tblp_reg, `CWNW_DID_LO, `CWNW_DID_HI);
  wire region_x1 = ctrl_reg[`CWNW_BIT_REG0];
  wire wr_target_ok = region_x1 && (is_uid || is_cfg);
  // protect bit 0 clear means protected
  wire protected_w = !prot_reg[0];
  wire wr_cmd = wr_acc && (a == `CWNW_OFF_CTRL) && wd[`CWNW_BIT_WR] && st_reg == CWNW_IDLE;
  wire wr_go = wr_cmd && ctrl_reg[`CWNW_BIT_WRITE_ENABLE_BIT];
  wire wr_bad = wr_go && (protected_w || !wr_target_ok || key_reg != CWNW_KOK);
  wire wr_start = wr_go && !wr_bad;
  wire rd_cmd = wr_acc && (a == `CWNW_OFF_CTRL) && wd[`CWNW_BIT_RD];
  wire done_ev = (st_reg == CWNW_DONE);
  wire flag_rd_clr = rd_acc && (a == `CWNW_OFF_FLAG);
  wire [3:0] uid_ix = tblp_reg[3:0];
  wire [3:0] cfg_ix = tblp_reg[3:0];
  wire [7:0] rd_byte = !region_x1 ? 8'h00 :
                       is_uid ? uid_mem[uid_ix] :
                       (is_cfg && cfg_ix < 4'd12) ? cfg_mem[cfg_ix] :
                       is_did ? DEV_ID_VALUE : 8'h00;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign cpu_stall = (st_reg != CWNW_IDLE);
  assign irq_out = |(flag_reg & ien_reg);
  assign irq_high_pri = irq_out && ipri_reg[`CWNW_BIT_DONE];
  assign cfg_word_out = cfg_out_reg;
  assign prdata = {24'h0000_00, rdata_reg};

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_acc && a == `CWNW_OFF_CTRL) begin
      // start bits only set by hardware rules, error cleared by software
      ctrl_next = (wd & `CWNW_CTRL_MASK & 8'hFC) | (ctrl_reg & 8'h03);
      ctrl_next[`CWNW_BIT_WRITE_ERROR_FLAG] = wd[`CWNW_BIT_WRITE_ERROR_FLAG] & ctrl_reg[`CWNW_BIT_WRITE_ERROR_FLAG];
    end
    if (wr_start) ctrl_next[`CWNW_BIT_WR] = 1'b1;
    if (wr_bad) begin
      ctrl_next[`CWNW_BIT_WR] = 1'b0;
      ctrl_next[`CWNW_BIT_WRITE_ERROR_FLAG] = 1'b1;
    end
    if (done_ev) ctrl_next[`CWNW_BIT_WR] = 1'b0;
    ctrl_next[`CWNW_BIT_RD] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= 8'h00;
      key_reg <= CWNW_K0;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      if (wr_acc && a == `CWNW_OFF_KEY) begin
        if (key_reg == CWNW_K0 && wd == `CWNW_KEY_FIRST) key_reg <= CWNW_K1;
        else if (key_reg == CWNW_K1 && wd == `CWNW_KEY_SECOND) key_reg <= CWNW_KOK;
        else key_reg <= CWNW_K0;
      end else if (wr_go) key_reg <= CWNW_K0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      adrl_reg <= 8'h00;
      tblp_reg <= 22'h00_0000;
      tlat_reg <= 8'h00;
      ien_reg <= 8'h00;
      ipri_reg <= `CWNW_RST_IPRI;
      prot_reg <= 8'h01;
    end else if (clk_en && wr_acc) begin
      if (a == `CWNW_OFF_ADRL) adrl_reg <= wd;
      if (a == `CWNW_OFF_TBLU) tblp_reg[21:16] <= wd[5:0];
      if (a == `CWNW_OFF_TBLH) tblp_reg[15:8] <= wd;
      if (a == `CWNW_OFF_TBLL) tblp_reg[7:0] <= wd;
      if (a == `CWNW_OFF_TLAT) tlat_reg <= wd;
      if (a == `CWNW_OFF_IEN) ien_reg <= wd & 8'h20;
      if (a == `CWNW_OFF_IPRI) ipri_reg <= wd & 8'h20;
      if (a == `CWNW_OFF_PROT) prot_reg <= wd & 8'h01;
    end
  end

  // data register: written by software, loaded by read command or write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) dat_reg <= 8'h00;
    else if (clk_en) begin
      if (rd_cmd) dat_reg <= rd_byte;
      else if (wr_start) dat_reg <= tlat_reg;
      else if (wr_acc && a == `CWNW_OFF_DAT) dat_reg <= wd;
    end
  end

  // write engine: erase then program a single byte while the cpu is held
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= CWNW_IDLE;
      cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      case (st_reg)
        CWNW_IDLE: if (wr_start) begin
          st_reg <= CWNW_ERASE;
          cnt_reg <= 16'h0000;
        end
        CWNW_ERASE: st_reg <= CWNW_PROG;
        CWNW_PROG: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(WRITE_CYC - 1)) st_reg <= CWNW_DONE;
        end
        CWNW_DONE: st_reg <= CWNW_IDLE;
        default: st_reg <= CWNW_IDLE;
      endcase
    end
  end

  // array: erase then program one byte, no other byte touched
  // cleared on reset so the config output never carries unknowns into the cpu
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) uid_mem[i] <= 8'h00;
      for (int i = 0; i < 12; i++) cfg_mem[i] <= 8'h00;
    end else if (clk_en) begin
      if (st_reg == CWNW_ERASE) begin
        if (is_uid) uid_mem[uid_ix] <= 8'hFF;
        else if (cfg_ix < 4'd12) cfg_mem[cfg_ix] <= 8'hFF;
      end
      if (st_reg == CWNW_DONE) begin
        if (is_uid) uid_mem[uid_ix] <= dat_reg;
        else if (cfg_ix < 4'd12) cfg_mem[cfg_ix] <= dat_reg;
      end
    end
  end

  // config output only updates when the stall drops, never mid write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) cfg_out_reg <= 8'h00;
    else if (clk_en && !cpu_stall) cfg_out_reg <= cfg_mem[0];
  end

  // done flag: set wins over clear-on-read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) flag_reg <= 8'h00;
    else if (clk_en) begin
      if (done_ev) flag_reg[`CWNW_BIT_DONE] <= 1'b1;
      else if (flag_rd_clr) flag_reg <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rdata_reg <= 8'h00;
    else if (clk_en && psel && !penable && !pwrite) begin
      case (a)
        `CWNW_OFF_CTRL: rdata_reg <= ctrl_reg;
        `CWNW_OFF_ADRL: rdata_reg <= adrl_reg;
        `CWNW_OFF_DAT: rdata_reg <= dat_reg;
        `CWNW_OFF_TBLU: rdata_reg <= {2'b00, tblp_reg[21:16]};
        `CWNW_OFF_TBLH: rdata_reg <= tblp_reg[15:8];
        `CWNW_OFF_TBLL: rdata_reg <= tblp_reg[7:0];
        `CWNW_OFF_TLAT: rdata_reg <= tlat_reg;
        `CWNW_OFF_FLAG: rdata_reg <= flag_reg;
        `CWNW_OFF_IEN: rdata_reg <= ien_reg;
        `CWNW_OFF_IPRI: rdata_reg <= ipri_reg;
        `CWNW_OFF_PROT: rdata_reg <= prot_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  sequence start_seq;
    wr_start;
  endsequence
  sequence finish_seq;
    done_ev ##1 !cpu_stall;
  endsequence

  bad_write_err_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_bad |=> ctrl_reg[`CWNW_BIT_WRITE_ERROR_FLAG] && !ctrl_reg[`CWNW_BIT_WR] && st_reg == CWNW_IDLE)
    else $error("bad write not flagged");
  no_write_enable_bit_ignore_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_cmd && !ctrl_reg[`CWNW_BIT_WRITE_ENABLE_BIT]) |=> st_reg == CWNW_IDLE && !ctrl_reg[`CWNW_BIT_WR])
    else $error("write ran without enable");
  locked_refuse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_go && key_reg != CWNW_KOK) |=> !cpu_stall)
    else $error("write ran without unlock");
  stall_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (start_seq and clk_en) |=> cpu_stall[*2])
    else $error("cpu not stalled");
  done_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (done_ev && clk_en) |=> flag_reg[`CWNW_BIT_DONE] && !ctrl_reg[`CWNW_BIT_WR])
    else $error("done flag missing");
  cfg_stable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cpu_stall |=> $stable(cfg_out_reg))
    else $error("config changed during stall");
  finish_seen_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (done_ev && clk_en) |-> finish_seq)
    else $error("stall not released");
  prio_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_high_pri |-> ipri_reg[`CWNW_BIT_DONE] && irq_out)
    else $error("priority misrouted");
  ctrl_bit5_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ctrl_reg[5])
    else $error("unimplemented bit set");
endmodule : cwnw_top
`default_nettype wire

// *** bench/cwnw_cpu_model.sv ***
// cpu side model: halts while the writer stalls it, logs stall length and count
// assumes cpu_stall and cfg_word_out come straight from the writer
`timescale 1ns/100ps
`default_nettype none
module cwnw_cpu_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cpu_stall,
  input wire logic [7:0] cfg_word_out,
  output logic [15:0] stall_len,
  output logic [7:0] n_stall,
  output logic cfg_moved
);
  logic [15:0] run;
  logic [7:0] cfg_prev;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run <= 16'h0000;
      stall_len <= 16'h0000;
      n_stall <= 8'h00;
      cfg_moved <= 1'b0;
      cfg_prev <= 8'h00;
    end else begin
      cfg_prev <= cfg_word_out;
      // no instruction retires while stalled, so run is the lost cycle count
      if (cpu_stall === 1'b1) begin
        run <= run + 16'h0001;
      end else if (run != 16'h0000) begin
        stall_len <= run;
        n_stall <= n_stall + 8'h01;
        run <= 16'h0000;
      end
      // a stalled core must not see the new value yet
      if (cpu_stall === 1'b1 && cfg_word_out !== cfg_prev) begin
        cfg_moved <= 1'b1;
      end
    end
  end
endmodule : cwnw_cpu_model
`default_nettype wire

// *** bench/cwnw_top_tb_top.sv ***
// self-checking bench for the config word writer over apb
// assumes no wait states are needed but waits on pready anyway
`timescale 1ns/100ps
`default_nettype none
`include "cwnw_regs.svh"
module cwnw_top_tb_top;
  logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, cpu_stall, irq_out, irq_high_pri, cfg_moved;
  logic [7:0] cfg_word_out, n_stall;
  logic [15:0] stall_len;
  int bad_count = 0, n_compared = 0, cyc = 0;
  // short program time keeps the run small; stall is erase + program + done
  cwnw_top #(.WRITE_CYC(4), .DEV_ID_VALUE(8'h5A)) uut (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_stall(cpu_stall), .cfg_word_out(cfg_word_out), .irq_out(irq_out),
    .irq_high_pri(irq_high_pri));
  cwnw_cpu_model cpu (.ref_clk(ref_clk), .rstn(rstn), .cpu_stall(cpu_stall),
    .cfg_word_out(cfg_word_out), .stall_len(stall_len), .n_stall(n_stall),
    .cfg_moved(cfg_moved));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    check(nm, q, {24'h00_0000, e});
  endtask : rd
  // pointer and latch loaded before any command; key just before it
  task automatic cmd(input logic [21:0] p, input logic [7:0] d, input logic k, input logic [7:0] c);
    apb(1'b1, `CWNW_OFF_TBLU, {2'b00, p[21:16]});
    apb(1'b1, `CWNW_OFF_TBLH, p[15:8]);
    apb(1'b1, `CWNW_OFF_TBLL, p[7:0]);
    apb(1'b1, `CWNW_OFF_TLAT, d);
    // enable and region must already stand before the start bit is written
    apb(1'b1, `CWNW_OFF_CTRL, c & 8'hFC);
    if (k) apb(1'b1, `CWNW_OFF_KEY, `CWNW_KEY_FIRST);
    if (k) apb(1'b1, `CWNW_OFF_KEY, `CWNW_KEY_SECOND);
    apb(1'b1, `CWNW_OFF_CTRL, c);
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 40 && cpu_stall !== 1'b0; i++) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask : cmd
  task automatic t_reset;
    rd(`CWNW_OFF_CTRL, 8'h00, "ctrl");
    rd(`CWNW_OFF_DAT, 8'h00, "data");
    rd(`CWNW_OFF_IPRI, 8'h20, "prio");
    rd(12'h0FC, 8'h00, "unmapped");
    apb(1'b1, `CWNW_OFF_CTRL, 8'hF0);
    rd(`CWNW_OFF_CTRL, 8'hD0, "ctrl bits");
    apb(1'b1, `CWNW_OFF_CTRL, 8'h00);
  endtask : t_reset
  task automatic t_refuse;
    cmd(22'h30_0000, 8'hA5, 1'b0, 8'h46);
    check("no key", {n_stall, cfg_word_out}, 16'h0000);
    rd(`CWNW_OFF_CTRL, 8'h4C, "no key err");
    cmd(22'h30_0000, 8'hA5, 1'b1, 8'h42);
    check("no write_enable_bit", {n_stall, cfg_word_out}, 16'h0000);
    rd(`CWNW_OFF_CTRL, 8'h40, "no write_enable_bit ctrl");
    // an ignored command leaves the key armed, so break it by hand
    apb(1'b1, `CWNW_OFF_KEY, 8'h00);
    apb(1'b1, `CWNW_OFF_CTRL, 8'h00);
  endtask : t_refuse
  task automatic t_write;
    apb(1'b1, `CWNW_OFF_IEN, 8'h20);
    cmd(22'h30_0000, 8'hA5, 1'b1, 8'h46);
    check("stall", {stall_len, n_stall}, {16'h0006, 8'h01});
    check("cfg", {cfg_moved, cfg_word_out}, {1'b0, 8'hA5});
    check("irq", {irq_out, irq_high_pri}, 2'b11);
    rd(`CWNW_OFF_CTRL, 8'h44, "wr clear");
    rd(`CWNW_OFF_DAT, 8'hA5, "data wr");
    rd(`CWNW_OFF_FLAG, 8'h20, "flag");
    rd(`CWNW_OFF_FLAG, 8'h00, "flag clr");
    apb(1'b1, `CWNW_OFF_IPRI, 8'h00);
    cmd(22'h20_000F, 8'h3C, 1'b1, 8'h46);
    check("low pri", {irq_out, irq_high_pri, cfg_word_out}, {2'b10, 8'hA5});
    cmd(22'h20_000F, 8'h00, 1'b0, 8'h41);
    rd(`CWNW_OFF_DAT, 8'h3C, "uid rd");
    cmd(22'h3F_FFFC, 8'h11, 1'b1, 8'h46);
    apb(1'b1, `CWNW_OFF_CTRL, 8'h00);
    cmd(22'h3F_FFFE, 8'h00, 1'b0, 8'h41);
    rd(`CWNW_OFF_DAT, 8'h5A, "dev id ro");
    check("stalls", n_stall, 8'h02);
  endtask : t_write
  task automatic t_error;
    cmd(22'h25_0000, 8'h77, 1'b1, 8'h46);
    rd(`CWNW_OFF_CTRL, 8'h4C, "bad addr");
    apb(1'b1, `CWNW_OFF_PROT, 8'h00);
    cmd(22'h30_0000, 8'h77, 1'b1, 8'h46);
    rd(`CWNW_OFF_CTRL, 8'h4C, "protect");
    check("no change", {n_stall, cfg_word_out}, {8'h02, 8'hA5});
  endtask : t_error
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_refuse();
    t_write();
    t_error();
    wrap_up();
  end
endmodule : cwnw_top_tb_top
`default_nettype wire
